// >>> pkg/uasd_map.svh
// address map constants for the unified address space decoder
// assumes 24-bit byte addresses, included by bare name
`ifndef UASD_MAP_SVH
`define UASD_MAP_SVH
`define UASD_ADDR_W        24
`define UASD_SEG_MSB       23
`define UASD_SEG_LSB       16
`define UASD_PAGE_MSB      15
`define UASD_PAGE_LSB      14
`define UASD_MREG_LO       24'hFFFF00
`define UASD_TRAP_LO       24'hF00000
`define UASD_EPR_HI        24'hEFFFFF
`define UASD_EPR_LO        24'hE80000
`define UASD_EPR_TOP       24'hE87FFF
`define UASD_PSR_LO        24'hE00000
`define UASD_PSR_TOP       24'hE07FFF
`define UASD_FLR_HI        24'hDFFFFF
`define UASD_FL3_LO        24'hCC0000
`define UASD_FL3_TOP       24'hCCFFFF
`define UASD_FL2_LO        24'hC80000
`define UASD_FL1_LO        24'hC40000
`define UASD_FL0_LO        24'hC00000
`define UASD_FL_RSV_LO     24'hC0F000
`define UASD_FL_RSV_HI     24'hC0FFFF
`define UASD_EXT_HI        24'hBFFFFF
`define UASD_XIO_LO        24'h210000
`define UASD_XIO_HI        24'h3FFFFF
`define UASD_LXB_LO        24'h200000
`define UASD_LXB_HI        24'h20FFFF
`define UASD_SEG0_HI       24'h00FFFF
`define UASD_SFR_LO        24'h00FE00
`define UASD_DPR_LO        24'h00F600
`define UASD_DPR_BIT_LO    24'h00FD00
`define UASD_DPR_HI        24'h00FDFF
`define UASD_DPR_RSV_LO    24'h00F200
`define UASD_EREG_LO       24'h00F000
`define UASD_EREG_HI       24'h00F1FF
`define UASD_AREG_LO       24'h00E000
`define UASD_AREG_HI       24'h00EFFF
`define UASD_DSR_LO        24'h00A000
`define UASD_DSR_HI        24'h00DFFF
`define UASD_DSR_RSV_LO    24'h008000
`define UASD_SECT_LSB      12
`define UASD_BLK_LSB       7
`define UASD_LINE_LSB      4
`define UASD_PSR_OFF_W     15
`define UASD_SECT_NUM_W    8
`define UASD_CLUSTER_SH    2
`define UASD_CLUSTERS      64
`define UASD_ECC_W         6
`endif

// >>> pkg/uasd_pkg.sv
// types for the unified address space decoder
// assumes uasd_map.svh supplies the numeric map
package uasd_pkg;
  typedef enum logic [4:0] {
    TGT_EXT, TGT_XIO, TGT_PBUS, TGT_AREG, TGT_EREG, TGT_DUAL_PORT_RAM, TGT_SFR,
    TGT_DMEM, TGT_PROGRAM_SRAM, TGT_EPRAM, TGT_FLASH0, TGT_FLASH1, TGT_FLASH2,
    TGT_FLASH3, TGT_MREG, TGT_TRAP
  } uasd_target_e;
  typedef enum logic {
    PATH_DATA, PATH_CODE
  } uasd_path_e;
endpackage : uasd_pkg

// >>> rtl/uasd_ecc_check.sv
// parity / single-error-correcting check on one 16-bit memory word
// assumes a Hamming code with an overall parity bit in checkBits[5]
`timescale 1ns/1ps
`include "uasd_map.svh"
module uasd_ecc_check #(
  parameter int DATA_W = 16
) (
  input  wire logic [DATA_W-1:0]      rawData,
  input  wire logic [`UASD_ECC_W-1:0] checkBits,
  input  wire logic                   parityMode,
  input  wire logic                   eccMode,
  output logic      [DATA_W-1:0]      fixedData,
  output logic                        errDetected,
  output logic                        errCorrected
);
  logic [4:0] synd;
  logic       parAll;
  logic [4:0] pos [DATA_W];
  // data bit i sits at Hamming position i+ (index skipping powers of two)
  always_comb begin
    int p;
    p = 1;
    synd = 5'h00;
    for (int i = 0; i < DATA_W; i++) begin
      p = p + 1;
      while ((p & (p - 1)) == 0) p = p + 1;
      pos[i] = p[4:0];
      if (rawData[i]) synd = synd ^ p[4:0];
    end
    synd = synd ^ checkBits[4:0];
  end
  assign parAll = ^{rawData, checkBits};
  // parity only detects; ecc corrects a lone flipped data bit
  always_comb begin
    fixedData    = rawData;
    errCorrected = 1'b0;
    errDetected  = 1'b0;
    if (eccMode && parAll) begin
      for (int i = 0; i < DATA_W; i++) begin
        if (pos[i] == synd) begin
          fixedData[i] = ~rawData[i];  // [R21]
        end
      end
      errCorrected = 1'b1;             // [R21]
    end else if (eccMode && synd != 5'h00) begin
      errDetected = 1'b1;
    end else if (parityMode && !eccMode && parAll) begin
      errDetected = 1'b1;              // [R20]
    end
  end
endmodule : uasd_ecc_check

// >>> rtl/uasd_decoder.sv
// address decoder and router for the 16-Mbyte linear address space
// assumes one request per enabled cycle from code fetch or data transfer side
// Functional notes
// R1 - one linear space holds code, data, registers and I/O
// R2 - 16 Mbytes as 256 segments of 64K, four 16K pages each
// R3 - byte and word accesses accepted at every address
// R4 - internal data memories and register areas decode in segment 0
// R5 - reserved ranges go to the external bus when it exists
// R6 - external I/O range disables pipeline optimisations
// R7 - code fetch manager serves fetches and program memories
// R8 - data transfer manager serves data, data SRAM and peripherals
// R9 - programmable-size region of program SRAM blocks writes
// R10 - upper 256 bytes of dual-port RAM bit addressable, also register use
// R11 - register bank of 16 words, low eight also as byte halves
// R12 - special and extended register areas are 512 bytes each, word-wide
// R13 - software writes only zeros to unused register addresses
// R14 - top 4K sector of first flash segment reserved internally
// R15 - flash in 4K sectors, programmed in 128-byte blocks
// R16 - flash reads are 128-bit wide
// R17 - whole flash read protectable, password unlock temporary
// R18 - different flash modules work concurrently
// R19 - sectors grouped into clusters sharing one write-protect bit
// R20 - parity error detected and the data discarded
// R21 - ecc single-bit error corrected before delivery
// R22 - every access selects exactly one target by map boundaries
`timescale 1ns/1ps
`include "uasd_map.svh"
module uasd_decoder #(
  parameter int  ADDR_W   = `UASD_ADDR_W,
  parameter int  DATA_W   = 16,
  parameter bit  HAS_XBUS = 1'b1
) (
  input  wire logic                      clk,
  input  wire logic                      srst,
  input  wire logic                      clkEn,
  input  wire logic                      reqValid,
  input  wire logic                      reqCode,
  input  wire logic                      reqWrite,
  input  wire logic                      reqByte,
  input  wire logic                      reqBit,
  input  wire logic                      reqGprUse,
  input  wire logic [ADDR_W-1:0]         reqAddr,
  input  wire logic [`UASD_PSR_OFF_W-1:0] psramProtSize,
  input  wire logic [`UASD_CLUSTERS-1:0] flashWrProt,
  input  wire logic                      flashRdProt,
  input  wire logic                      pwUnlock,
  input  wire logic                      pwRelock,
  input  wire logic                      parityEn,
  input  wire logic                      eccEn,
  input  wire logic [DATA_W-1:0]         memData,
  input  wire logic [`UASD_ECC_W-1:0]    memCheck,
  input  wire logic                      memValid,
  output logic                           selValid,
  output uasd_pkg::uasd_target_e         selTarget,
  output uasd_pkg::uasd_path_e           selPath,
  output logic [ADDR_W-1:0]              selAddr,
  output logic                           selByte,
  output logic                           selWrite,
  output logic [7:0]                     selSegment,
  output logic [1:0]                     selPage,
  output logic                           selExtBus,
  output logic                           noPipeOpt,
  output logic                           bitOk,
  output logic                           accessTrap,
  output logic                           wrBlocked,
  output logic                           rdBlocked,
  output logic                           flashWide,
  output logic [3:0]                     flashBusy,
  output logic [`UASD_SECT_NUM_W-1:0]    flashSector,
  output logic [4:0]                     flashBlock,
  output logic                           rdValid,
  output logic [DATA_W-1:0]              rdData,
  output logic                           rdError,
  output logic                           rdCorrected
);
  // range compare, inclusive
  function automatic logic inR(input logic [ADDR_W-1:0] a, lo, hi);
    return (a >= lo) && (a <= hi);
  endfunction : inR

  wire logic [ADDR_W-1:0] a = reqAddr;
  // exact-fit ranges in descending priority; only one target range can match, hitFlRsv lies inside hitFl0
  wire logic hitMreg  = a >= `UASD_MREG_LO;
  wire logic hitTrap  = inR(a, `UASD_TRAP_LO, `UASD_MREG_LO - 24'h000001);
  wire logic hitEpr   = inR(a, `UASD_EPR_LO, `UASD_EPR_TOP);
  wire logic hitEprR  = inR(a, `UASD_EPR_TOP + 24'h000001, `UASD_EPR_HI);
  wire logic hitPsr   = inR(a, `UASD_PSR_LO, `UASD_PSR_TOP);
  wire logic hitPsrR  = inR(a, `UASD_PSR_TOP + 24'h000001, `UASD_EPR_LO - 24'h000001);
  wire logic hitFlR   = inR(a, `UASD_FL3_TOP + 24'h000001, `UASD_FLR_HI);
  wire logic hitFl3   = inR(a, `UASD_FL3_LO, `UASD_FL3_TOP);
  wire logic hitFl2   = inR(a, `UASD_FL2_LO, `UASD_FL3_LO - 24'h000001);
  wire logic hitFl1   = inR(a, `UASD_FL1_LO, `UASD_FL2_LO - 24'h000001);
  wire logic hitFl0   = inR(a, `UASD_FL0_LO, `UASD_FL1_LO - 24'h000001);
  wire logic hitXio   = inR(a, `UASD_XIO_LO, `UASD_XIO_HI);
  wire logic hitLxb   = inR(a, `UASD_LXB_LO, `UASD_LXB_HI);
  wire logic seg0     = a <= `UASD_SEG0_HI;
  wire logic hitSfr   = seg0 && a >= `UASD_SFR_LO;                             // [R4]
  wire logic hitDpr   = inR(a, `UASD_DPR_LO, `UASD_DPR_HI);                   // [R4]
  wire logic hitDprR  = inR(a, `UASD_DPR_RSV_LO, `UASD_DPR_LO - 24'h000001);
  wire logic hitEreg  = inR(a, `UASD_EREG_LO, `UASD_EREG_HI);                  // [R12]
  wire logic hitAreg  = inR(a, `UASD_AREG_LO, `UASD_AREG_HI);
  wire logic hitDsr   = inR(a, `UASD_DSR_LO, `UASD_DSR_HI);                   // [R4]
  wire logic hitDsrR  = inR(a, `UASD_DSR_RSV_LO, `UASD_DSR_LO - 24'h000001);
  wire logic hitFlRsv = inR(a, `UASD_FL_RSV_LO, `UASD_FL_RSV_HI);            // [R14]
  // reserved holes: external bus when present, else a trap  [R5]
  wire logic hitRsv   = hitEprR | hitPsrR | hitFlR | hitDprR | hitDsrR | hitTrap;
  wire logic flashAny = hitFl0 | hitFl1 | hitFl2 | hitFl3;

  uasd_pkg::uasd_target_e tgt;
  always_comb begin                                                        // [R22] [R1]
    if (hitMreg)                 tgt = uasd_pkg::TGT_MREG;
    else if (hitRsv && HAS_XBUS) tgt = uasd_pkg::TGT_EXT;                  // [R5]
    else if (hitRsv)             tgt = uasd_pkg::TGT_TRAP;
    else if (hitEpr)             tgt = uasd_pkg::TGT_EPRAM;
    else if (hitPsr)             tgt = uasd_pkg::TGT_PROGRAM_SRAM;
    else if (hitFl3)             tgt = uasd_pkg::TGT_FLASH3;
    else if (hitFl2)             tgt = uasd_pkg::TGT_FLASH2;
    else if (hitFl1)             tgt = uasd_pkg::TGT_FLASH1;
    else if (hitFl0)             tgt = uasd_pkg::TGT_FLASH0;
    else if (hitXio)             tgt = uasd_pkg::TGT_XIO;
    else if (hitLxb)             tgt = uasd_pkg::TGT_PBUS;
    else if (hitSfr)             tgt = uasd_pkg::TGT_SFR;
    else if (hitDpr)             tgt = uasd_pkg::TGT_DUAL_PORT_RAM;
    else if (hitEreg)            tgt = uasd_pkg::TGT_EREG;
    else if (hitAreg)            tgt = uasd_pkg::TGT_AREG;
    else if (hitDsr)             tgt = uasd_pkg::TGT_DMEM;
    else                         tgt = uasd_pkg::TGT_EXT;
  end

  // code side owns fetches and program memories, data side the rest  [R7] [R8]
  wire logic progMem = hitPsr | hitEpr | flashAny;
  wire uasd_pkg::uasd_path_e path = (reqCode || progMem) ? uasd_pkg::PATH_CODE
                                                         : uasd_pkg::PATH_DATA;
  wire logic trapNow = tgt == uasd_pkg::TGT_TRAP;
  // a fetch aimed at data-only areas has no code path; it traps
  wire logic codeBad = reqCode && (hitSfr | hitEreg | hitAreg | hitDsr);

  // program_sram protected region counts up from the base
  wire logic [`UASD_PSR_OFF_W-1:0] psrOff = a[`UASD_PSR_OFF_W-1:0];
  wire logic psrWrBlk = hitPsr && reqWrite && (psrOff < psramProtSize);     // [R9]

  // flash sector and cluster for write protection
  wire logic [`UASD_SECT_NUM_W-1:0] sect = a[`UASD_SECT_LSB +: `UASD_SECT_NUM_W];  // [R15]
  wire logic [5:0] cluster = sect[`UASD_CLUSTER_SH +: 6];                  // [R19]
  wire logic flWrBlk = flashAny && reqWrite && (flashWrProt[cluster] || hitFlRsv);  // [R19] [R14]

  // read protection latch, opened by password, closed again by relock
  logic unlock_reg;
  logic unlock_next;
  assign unlock_next = pwRelock ? 1'b0 : (pwUnlock ? 1'b1 : unlock_reg);
  wire logic flRdBlk = flashAny && !reqWrite && !reqCode && flashRdProt && !unlock_reg;  // [R17]

  // bit addressing: top 256 bytes of dual_port_ram, register areas, or as register  [R10]
  wire logic bitArea = inR(a, `UASD_DPR_BIT_LO, `UASD_DPR_HI) | hitSfr | hitEreg
                     | (hitDpr && reqGprUse);
  // register-bank use must stay inside dual_port_ram; low-eight byte rule  [R11]
  wire logic gprBad = reqGprUse && (!hitDpr || (reqByte && a[4]));
  wire logic bitBad = reqBit && !bitArea;

  wire logic deny = trapNow | codeBad | gprBad | bitBad | psrWrBlk | flWrBlk | flRdBlk;

  // concurrent flash modules: each module has its own busy bit, set in the cycle after an accepted request  [R18]
  wire logic [3:0] flHit = {hitFl3, hitFl2, hitFl1, hitFl0};
  wire logic go = reqValid && clkEn;

  always_ff @(posedge clk) begin
    if (srst) begin
      unlock_reg <= 1'b0;
    end else if (clkEn) begin
      unlock_reg <= unlock_next;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      selValid    <= 1'b0;
      selTarget   <= uasd_pkg::TGT_EXT;
      selPath     <= uasd_pkg::PATH_DATA;
      selAddr     <= '0;
      selByte     <= 1'b0;
      selWrite    <= 1'b0;
      selSegment  <= 8'h00;
      selPage     <= 2'h0;
      selExtBus   <= 1'b0;
      noPipeOpt   <= 1'b0;
      bitOk       <= 1'b0;
      accessTrap  <= 1'b0;
      wrBlocked   <= 1'b0;
      rdBlocked   <= 1'b0;
      flashWide   <= 1'b0;
      flashBusy   <= 4'h0;
      flashSector <= '0;
      flashBlock  <= 5'h00;
    end else if (clkEn) begin
      selValid    <= reqValid && !deny;                                     // [R22]
      selTarget   <= tgt;
      selPath     <= path;                                                 // [R7] [R8]
      selAddr     <= reqAddr;                                              // [R3]
      selByte     <= reqByte;                                              // [R3]
      selWrite    <= reqWrite;
      selSegment  <= a[`UASD_SEG_MSB:`UASD_SEG_LSB];                       // [R2]
      selPage     <= a[`UASD_PAGE_MSB:`UASD_PAGE_LSB];                     // [R2]
      selExtBus   <= reqValid && !deny && (tgt == uasd_pkg::TGT_EXT ||
                     tgt == uasd_pkg::TGT_XIO || tgt == uasd_pkg::TGT_PBUS);  // [R5]
      noPipeOpt   <= reqValid && hitXio;                                   // [R6]
      bitOk       <= reqValid && reqBit && bitArea;                        // [R10]
      accessTrap  <= reqValid && (trapNow | codeBad | gprBad | bitBad);
      wrBlocked   <= reqValid && (psrWrBlk | flWrBlk);                     // [R9] [R19]
      rdBlocked   <= reqValid && flRdBlk;                                  // [R17]
      flashWide   <= reqValid && flashAny && !reqWrite;                    // [R16]
      flashBusy   <= go && !deny ? flHit : 4'h0;                           // [R18]
      flashSector <= sect;                                                 // [R15]
      flashBlock  <= a[`UASD_SECT_LSB-1:`UASD_BLK_LSB];                    // [R15]
    end
  end

  // returned memory words pass through the error checker
  logic [DATA_W-1:0] fixData;
  logic              eDet;
  logic              eCor;
  uasd_ecc_check #(
    .DATA_W (DATA_W)
  ) i_uasd_ecc_check (
    .rawData      (memData),
    .checkBits    (memCheck),
    .parityMode   (parityEn),
    .eccMode      (eccEn),
    .fixedData    (fixData),
    .errDetected  (eDet),
    .errCorrected (eCor)
  );

  always_ff @(posedge clk) begin
    if (srst) begin
      rdValid     <= 1'b0;
      rdData      <= '0;
      rdError     <= 1'b0;
      rdCorrected <= 1'b0;
    end else if (clkEn) begin
      // detected error: data withheld, never marked valid  [R20]
      rdValid     <= memValid && !eDet;
      rdData      <= eDet ? '0 : fixData;                                  // [R21]
      rdError     <= memValid && eDet;                                     // [R20]
      rdCorrected <= memValid && eCor;                                     // [R21]
    end
  end
endmodule : uasd_decoder

// >>> sim/uasd_decoder_checker.sv
// port-level assertions for the address decoder
// assumes one clock, srst synchronous high, outputs one cycle after the request
`timescale 1ns/1ps
`include "uasd_map.svh"
module uasd_decoder_checker #(
  parameter int ADDR_W   = `UASD_ADDR_W,
  parameter int DATA_W   = 16,
  parameter bit HAS_XBUS = 1'b1
) (
  input wire logic                          clk,
  input wire logic                          srst,
  input wire logic                          clkEn,
  input wire logic                          reqValid,
  input wire logic                          reqCode,
  input wire logic                          reqWrite,
  input wire logic                          reqBit,
  input wire logic [ADDR_W-1:0]             reqAddr,
  input wire logic [`UASD_PSR_OFF_W-1:0]    psramProtSize,
  input wire logic                          flashRdProt,
  input wire logic                          memValid,
  input wire uasd_pkg::uasd_target_e        selTarget,
  input wire uasd_pkg::uasd_path_e          selPath,
  input wire logic [7:0]                    selSegment,
  input wire logic [1:0]                    selPage,
  input wire logic                          selExtBus,
  input wire logic                          noPipeOpt,
  input wire logic                          bitOk,
  input wire logic                          wrBlocked,
  input wire logic                          flashWide,
  input wire logic [3:0]                    flashBusy,
  input wire logic                          rdValid,
  input wire logic [DATA_W-1:0]             rdData,
  input wire logic                          rdError
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  wire inXio = reqAddr >= `UASD_XIO_LO && reqAddr <= `UASD_XIO_HI;
  wire inPsr = reqAddr >= `UASD_PSR_LO && reqAddr <= `UASD_PSR_TOP;
  wire inRsv = reqAddr >= `UASD_FL_RSV_LO && reqAddr <= `UASD_FL_RSV_HI;
  wire inProt = reqAddr >= `UASD_PSR_LO && reqAddr < `UASD_PSR_LO + psramProtSize;
  wire inFl0 = reqAddr >= `UASD_FL0_LO && reqAddr < `UASD_FL1_LO;
  wire inTrap = reqAddr >= `UASD_TRAP_LO && reqAddr < `UASD_MREG_LO;
  wire inBit = reqAddr >= `UASD_DPR_BIT_LO && reqAddr <= `UASD_DPR_HI;
  sequence s_take;
    clkEn && reqValid;
  endsequence
  sequence s_ret;
    clkEn && memValid;
  endsequence
  chk_seg_page: assert property (s_take |=> selSegment == $past(reqAddr[23:16])
    && selPage == $past(reqAddr[15:14])) else $error("segment or page field wrong");
  chk_xio_nopipe: assert property (s_take |=> noPipeOpt == $past(inXio))
    else $error("pipeline hold flag wrong");
  chk_program_sram_code: assert property (s_take ##0 (inPsr && !reqWrite) |=>
    selTarget == uasd_pkg::TGT_PROGRAM_SRAM && selPath == uasd_pkg::PATH_CODE)
    else $error("program ram not routed to code side");
  chk_flash_rsv: assert property (s_take ##0 (reqWrite && inRsv) |=> wrBlocked)
    else $error("write to reserved flash sector not blocked");
  chk_program_sram_prot: assert property (s_take ##0 (reqWrite && inProt) |=> wrBlocked)
    else $error("protected program ram write not blocked");
  chk_flash_wide: assert property (s_take ##0 (inFl0 && !reqWrite && !flashRdProt)
    |=> flashWide && flashBusy == 4'h1) else $error("flash read not wide");
  chk_ext_route: assert property (s_take ##0 (HAS_XBUS && inTrap) |=>
    selExtBus && selTarget == uasd_pkg::TGT_EXT) else $error("reserved not external");
  chk_ret_pair: assert property (s_ret |=> rdValid != rdError)
    else $error("returned word neither delivered nor flagged");
  chk_err_drop: assert property (rdError |-> !rdValid && rdData == '0)
    else $error("erroneous word delivered");
  chk_bit_area: assert property (s_take ##0 (reqBit && inBit) |=> bitOk)
    else $error("bit access in bit area refused");
endmodule : uasd_decoder_checker
bind uasd_decoder uasd_decoder_checker #(.ADDR_W(ADDR_W), .DATA_W(DATA_W), .HAS_XBUS(HAS_XBUS))
  i_uasd_decoder_checker (.clk, .srst, .clkEn, .reqValid, .reqCode, .reqWrite, .reqBit,
  .reqAddr, .psramProtSize, .flashRdProt, .memValid, .selTarget, .selPath, .selSegment,
  .selPage, .selExtBus, .noPipeOpt, .bitOk, .wrBlocked, .flashWide, .flashBusy, .rdValid,
  .rdData, .rdError);

// >>> sim/uasd_mem_model.sv
// memory side model: returns one coded word a cycle after send
// assumes single-error code, overall parity in check bit 5
`timescale 1ns/1ps
module uasd_mem_model (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        send,
  input  wire logic [15:0] word,
  input  wire logic        flip,
  input  wire logic [3:0]  flipBit,
  output logic             memValid,
  output logic [15:0]      memData,
  output logic [5:0]       memCheck
);
  localparam logic [4:0] POS [16] = '{5'h03, 5'h05, 5'h06, 5'h07, 5'h09, 5'h0A, 5'h0B,
    5'h0C, 5'h0D, 5'h0E, 5'h0F, 5'h11, 5'h12, 5'h13, 5'h14, 5'h15};
  function automatic logic [5:0] enc(input logic [15:0] d);
    logic [4:0] s;
    s = 5'h00;
    for (int i = 0; i < 16; i++) begin
      s = d[i] ? s ^ POS[i] : s;
    end
    return {^d ^ ^s, s};
  endfunction : enc
  always_ff @(posedge clk) begin
    memValid <= srst ? 1'b0 : send;
    if (send) begin
      memData  <= word ^ (flip ? 16'h0001 << flipBit : 16'h0000);
      memCheck <= enc(word);
    end else if (memValid) begin
      // released word: invert so stale data never looks valid
      memData  <= ~memData;
      memCheck <= ~memCheck;
    end
  end
endmodule : uasd_mem_model

// >>> sim/tb_top.sv
// self-checking bench for the address decoder
// assumes the decoder answers every request one cycle later
`timescale 1ns/1ps
module tb_top;
  logic clk, srst, clkEn, reqValid, reqCode, reqWrite, reqByte, reqBit, reqGprUse;
  logic flashRdProt, pwUnlock, pwRelock, parityEn, eccEn, memValid, send, flip;
  logic selValid, selByte, selWrite, selExtBus, noPipeOpt, bitOk, accessTrap, wrBlocked;
  logic rdBlocked, flashWide, rdValid, rdError, rdCorrected;
  logic [23:0] reqAddr, selAddr;
  logic [14:0] psramProtSize;
  logic [63:0] flashWrProt;
  logic [15:0] memData, rdData, word;
  logic [5:0]  memCheck;
  logic [7:0]  selSegment, flashSector;
  logic [3:0]  flashBusy, flipBit;
  logic [4:0]  flashBlock;
  logic [1:0]  selPage;
  uasd_pkg::uasd_target_e selTarget;
  uasd_pkg::uasd_path_e   selPath;
  int fails, checksDone, cycles;
  uasd_decoder i_uasd_decoder (.*);
  uasd_mem_model i_uasd_mem_model (.*);
  task automatic cmpv(input string n, input logic [23:0] e, input logic [23:0] g);
    checksDone++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : cmpv
  // k packs code, write, byte, bit, register use
  task automatic req(input logic [23:0] a, input logic [4:0] k);
    @(posedge clk);
    reqValid <= 1'b1;
    reqAddr <= a;
    {reqCode, reqWrite, reqByte, reqBit, reqGprUse} <= k;
    @(posedge clk);
    reqValid <= 1'b0;
    @(negedge clk);
  endtask : req
  task automatic mem(input logic [15:0] w, input logic f, input logic [3:0] b);
    @(posedge clk);
    {send, word, flip, flipBit} <= {1'b1, w, f, b};
    @(posedge clk);
    send <= 1'b0;
    @(posedge clk);
    @(negedge clk);
  endtask : mem
  task automatic t_map;
    logic [23:0] a [16] = '{24'hE00010, 24'hE80000, 24'hC00000, 24'hC40000, 24'hC80000,
      24'hCC0000, 24'h00DFFF, 24'h00F600, 24'h00FFFF, 24'h00F1FF, 24'h00E000, 24'h200000,
      24'h210000, 24'hF00000, 24'hFFFF00, 24'hE08000};
    uasd_pkg::uasd_target_e t [16] = '{uasd_pkg::TGT_PROGRAM_SRAM, uasd_pkg::TGT_EPRAM,
      uasd_pkg::TGT_FLASH0, uasd_pkg::TGT_FLASH1, uasd_pkg::TGT_FLASH2, uasd_pkg::TGT_FLASH3,
      uasd_pkg::TGT_DMEM, uasd_pkg::TGT_DUAL_PORT_RAM, uasd_pkg::TGT_SFR, uasd_pkg::TGT_EREG,
      uasd_pkg::TGT_AREG, uasd_pkg::TGT_PBUS, uasd_pkg::TGT_XIO, uasd_pkg::TGT_EXT,
      uasd_pkg::TGT_MREG, uasd_pkg::TGT_EXT};
    for (int i = 0; i < 16; i++) begin
      req(a[i], 5'h00);
      cmpv("target", t[i], selTarget);
      cmpv("accepted", 1'b1, selValid);
      cmpv("segment", a[i][23:16], selSegment);
      cmpv("page", a[i][15:14], selPage);
      cmpv("path", t[i] >= uasd_pkg::TGT_PROGRAM_SRAM && t[i] <= uasd_pkg::TGT_FLASH3, selPath);
    end
  endtask : t_map
  task automatic t_io;
    logic [23:0] a [4] = '{24'h20FFFF, 24'h210000, 24'h3FFFFF, 24'h400000};
    for (int i = 0; i < 4; i++) begin
      req(a[i], 5'h04);
      cmpv("pipe hold", i == 1 || i == 2, noPipeOpt);
      cmpv("external", 1'b1, selExtBus);
      cmpv("byte echo", 1'b1, selByte);
    end
  endtask : t_io
  task automatic t_prot;
    @(posedge clk);
    {psramProtSize, flashWrProt} <= {15'h0100, 64'h2};
    req(24'hE000FF, 5'h08);
    cmpv("blocked", 1'b1, wrBlocked);
    cmpv("accepted", 1'b0, selValid);
    cmpv("address", 24'hE000FF, selAddr);
    cmpv("write echo", 1'b1, selWrite);
    req(24'hE00100, 5'h08);
    cmpv("blocked", 1'b0, wrBlocked);
    req(24'hC0F000, 5'h08);
    cmpv("blocked", 1'b1, wrBlocked);
    req(24'hC07FFE, 5'h08);
    cmpv("blocked", 1'b1, wrBlocked);
    req(24'hC08000, 5'h08);
    cmpv("blocked", 1'b0, wrBlocked);
    req(24'hC41F80, 5'h00);
    cmpv("sector", 8'h41, flashSector);
    cmpv("wide", 1'b1, flashWide);
    cmpv("module", 4'h2, flashBusy);
    cmpv("block", 5'h1F, flashBlock);
  endtask : t_prot
  task automatic t_rdprot;
    @(posedge clk);
    flashRdProt <= 1'b1;
    req(24'hC40000, 5'h00);
    cmpv("read locked", 1'b1, rdBlocked);
    req(24'hC40000, 5'h10);
    cmpv("fetch locked", 1'b0, rdBlocked);
    @(posedge clk);
    pwUnlock <= 1'b1;
    @(posedge clk);
    pwUnlock <= 1'b0;
    req(24'hC40000, 5'h00);
    cmpv("read locked", 1'b0, rdBlocked);
    @(posedge clk);
    pwRelock <= 1'b1;
    @(posedge clk);
    pwRelock <= 1'b0;
    req(24'hCC0000, 5'h00);
    cmpv("read locked", 1'b1, rdBlocked);
  endtask : t_rdprot
  task automatic t_bits;
    req(24'h00FD00, 5'h02);
    cmpv("bit ok", 1'b1, bitOk);
    req(24'h00FC00, 5'h02);
    cmpv("bit trap", 2'b01, {bitOk, accessTrap});
    req(24'h00FC00, 5'h03);
    cmpv("bit ok", 1'b1, bitOk);
    req(24'h00F610, 5'h05);
    cmpv("half trap", 1'b1, accessTrap);
    req(24'h00F60E, 5'h05);
    cmpv("half trap", 1'b0, accessTrap);
  endtask : t_bits
  // clock enable low must freeze outputs; then a mid-run reset
  task automatic t_hold;
    @(posedge clk);
    {reqValid, reqAddr} <= {1'b1, 24'h210000};
    @(posedge clk);
    {clkEn, reqAddr} <= {1'b0, 24'h00F600};
    repeat (2) @(posedge clk);
    {srst, clkEn, reqValid} <= 3'b110;
    @(negedge clk);
    cmpv("frozen", {1'b1, 8'h21}, {noPipeOpt, selSegment});
    @(posedge clk);
    srst <= 1'b0;
    @(negedge clk);
    cmpv("reset", 15'h0000, {selValid, noPipeOpt, selSegment, selTarget});
    req(24'h00F600, 5'h00);
    cmpv("target", uasd_pkg::TGT_DUAL_PORT_RAM, selTarget);
  endtask : t_hold
  task automatic t_ecc;
    @(posedge clk);
    eccEn <= 1'b1;
    for (int b = 0; b < 16; b++) begin
      mem(16'hA5C3, b > 0, 4'(b));
      cmpv("word", {1'b1, b > 0, 16'hA5C3}, {rdValid, rdCorrected, rdData});
    end
    @(posedge clk);
    {eccEn, parityEn} <= 2'b01;
    mem(16'h3C5A, 1'b1, 4'h9);
    cmpv("dropped", {2'b01, 16'h0000}, {rdValid, rdError, rdData});
  endtask : t_ecc
  task automatic test_done;
    $display("checks %0d mismatches %0d", checksDone, fails);
    if (fails == 0 && checksDone > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : test_done
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      fails++;
      test_done();
    end
  end
  initial begin
    {srst, clkEn, reqValid, reqCode, reqWrite, reqByte, reqBit, reqGprUse} = 8'hC0;
    {flashRdProt, pwUnlock, pwRelock, parityEn, eccEn, send, flip} = 7'h00;
    {reqAddr, psramProtSize, flashWrProt, word, flipBit} = '0;
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    t_map();
    t_io();
    t_prot();
    t_rdprot();
    t_bits();
    t_hold();
    t_ecc();
    test_done();
  end
endmodule : tb_top
